/* trim_map.svh */
// register offsets, field positions, reset values and timing counts for the trim/dither bank
// assumes byte addressing on a 32-bit apb, one register per aligned word
`ifndef TRIM_MAP_SVH
`define TRIM_MAP_SVH
// printed offsets are register indices; byte address is four times the index
`define GAIN_A_IDX 10'h07A
`define GAIN_B_IDX 10'h07B
`define REF_IDX 10'h07C
`define TERM_A_IDX 10'h07E
`define TERM_B_IDX 10'h07F
`define DITHER_IDX 10'h09D
`define FUSE_STATUS_IDX 10'h0A0
`define REF_TRIM_MSB 3
`define DITHER_ON_BIT 0
`define DITHER_LARGE_BIT 1
`define ROUND_STEER_BIT 2
`define DITHER_RESET 8'h01
`define FUSE_LOAD_TIME_NS 64
`define CLK_PERIOD_NS 8
`define FUSE_LOAD_CYCLES ((`FUSE_LOAD_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

/* trim_pkg.sv */
// types for the trim/dither register bank
// assumes trim_map.svh supplies the numbers
package trim_pkg;
    typedef struct packed {
        logic [7:0] gain_a;
        logic [7:0] gain_b;
        logic [7:0] reference;
        logic [7:0] term_a;
        logic [7:0] term_b;
        logic [7:0] dither;
    } trim_set_type;

    typedef struct packed {
        logic dither_on;
        logic dither_large_select;
        logic rounding_error_steer;
    } dither_ctl_type;

    typedef enum logic [2:0] {
        LOAD_IDLE = 3'b001,
        LOAD_WAIT = 3'b010,
        LOAD_DONE = 3'b100
    } load_state_type;
endpackage

/* fuse_loader.sv */
// waits a fixed settle time after reset, then pulses a load of the fuse trim word
// assumes fuse data is static and on the same clock once settled
`include "trim_map.svh"
module fuse_loader
    import trim_pkg::*;
#(
    parameter int SETTLE_CYCLES = `FUSE_LOAD_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    output logic load_pulse,
    output logic loaded
);
    load_state_type state_reg;
    logic [15:0] count_reg;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= LOAD_IDLE;
            count_reg <= 16'h0000;
            load_pulse <= 1'b0;
            loaded <= 1'b0;
        end else begin
            load_pulse <= 1'b0;
            case (state_reg)
                LOAD_IDLE: begin
                    count_reg <= 16'h0000;
                    state_reg <= LOAD_WAIT;
                end
                LOAD_WAIT: begin
                    count_reg <= count_reg + 16'h0001;
                    if (count_reg == 16'(SETTLE_CYCLES - 1)) begin
                        load_pulse <= 1'b1;
                        state_reg <= LOAD_DONE;
                    end
                end
                LOAD_DONE: begin
                    loaded <= 1'b1;
                end
                default: begin
                    state_reg <= LOAD_IDLE;
                end
            endcase
        end
    end
endmodule

/* trim_dither_register_bank.sv */
// apb register bank holding gain, termination and reference trims plus dither control
// assumes fuse_trim is a static factory word on clk; analog consumers take the outputs
//
// Design decision made here: the APB slave port.
`include "trim_map.svh"
module trim_dither_register_bank
    import trim_pkg::*;
#(
    parameter int SETTLE_CYCLES = `FUSE_LOAD_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire trim_set_type fuse_trim,
    output logic [7:0] input_a_gain_adjust,
    output logic [7:0] input_b_gain_adjust,
    output logic [3:0] reference_voltage_adjust,
    output logic [7:0] input_a_termination_adjust,
    output logic [7:0] input_b_termination_adjust,
    output dither_ctl_type dither_control,
    output logic fuse_loaded
);
    logic [7:0] gain_a_reg;
    logic [7:0] gain_b_reg;
    logic [7:0] ref_reg;
    logic [7:0] term_a_reg;
    logic [7:0] term_b_reg;
    logic [7:0] dither_reg;
    logic load_pulse;
    logic loaded;
    logic setup;
    logic wr_en;
    logic [9:0] idx;
    logic hit;
    logic [7:0] rd_byte;

    // index match shared by write enables and read mux
    function automatic logic is_idx(input logic [9:0] a, input logic [9:0] r);
        return a == r;
    endfunction

    function automatic logic mapped(input logic [9:0] a);
        return is_idx(a, `GAIN_A_IDX) || is_idx(a, `GAIN_B_IDX) || is_idx(a, `REF_IDX) ||
            is_idx(a, `TERM_A_IDX) || is_idx(a, `TERM_B_IDX) || is_idx(a, `DITHER_IDX) ||
            is_idx(a, `FUSE_STATUS_IDX);
    endfunction

    fuse_loader #(
        .SETTLE_CYCLES(SETTLE_CYCLES)
    ) u_loader (
        .clk(clk),
        .rst_n(rst_n),
        .load_pulse(load_pulse),
        .loaded(loaded)
    );

    // no wait state: setup cycle, then access answers ready at once
    assign setup = psel && !penable;
    assign idx = paddr[11:2];
    assign hit = mapped(idx);
    // only the low byte lane carries register data
    assign wr_en = psel && penable && pwrite && pready && pstrb[0] && hit;

    // fuse load wins over a same-cycle software write, as a load only follows reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            gain_a_reg <= 8'h00;
        end else if (load_pulse) begin
            gain_a_reg <= fuse_trim.gain_a;
        end else if (wr_en && is_idx(idx, `GAIN_A_IDX)) begin
            gain_a_reg <= pwdata[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            gain_b_reg <= 8'h00;
        end else if (load_pulse) begin
            gain_b_reg <= fuse_trim.gain_b;
        end else if (wr_en && is_idx(idx, `GAIN_B_IDX)) begin
            gain_b_reg <= pwdata[7:0];
        end
    end

    // reference trim store, upper nibble kept too
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ref_reg <= 8'h00;
        end else if (load_pulse) begin
            ref_reg <= fuse_trim.reference;
        end else if (wr_en && is_idx(idx, `REF_IDX)) begin
            ref_reg <= pwdata[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            term_a_reg <= 8'h00;
        end else if (load_pulse) begin
            term_a_reg <= fuse_trim.term_a;
        end else if (wr_en && is_idx(idx, `TERM_A_IDX)) begin
            term_a_reg <= pwdata[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            term_b_reg <= 8'h00;
        end else if (load_pulse) begin
            term_b_reg <= fuse_trim.term_b;
        end else if (wr_en && is_idx(idx, `TERM_B_IDX)) begin
            term_b_reg <= pwdata[7:0];
        end
    end

    // dither starts enabled, fuse may then override
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dither_reg <= `DITHER_RESET;
        end else if (load_pulse) begin
            dither_reg <= fuse_trim.dither;
        end else if (wr_en && is_idx(idx, `DITHER_IDX)) begin
            dither_reg <= pwdata[7:0];
        end
    end

    always_comb begin
        rd_byte = 8'h00;
        if (is_idx(idx, `GAIN_A_IDX)) begin
            rd_byte = gain_a_reg;
        end else if (is_idx(idx, `GAIN_B_IDX)) begin
            rd_byte = gain_b_reg;
        end else if (is_idx(idx, `REF_IDX)) begin
            rd_byte = ref_reg;
        end else if (is_idx(idx, `TERM_A_IDX)) begin
            rd_byte = term_a_reg;
        end else if (is_idx(idx, `TERM_B_IDX)) begin
            rd_byte = term_b_reg;
        end else if (is_idx(idx, `DITHER_IDX)) begin
            rd_byte = dither_reg;
        end else if (is_idx(idx, `FUSE_STATUS_IDX)) begin
            rd_byte = {7'h00, loaded};
        end
    end

    // bus answer: ready one cycle after setup, unmapped answers error
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= setup;
            pslverr <= setup && !hit;
            if (setup && !pwrite) begin
                prdata <= {24'h000000, rd_byte};
            end else if (!psel) begin
                prdata <= 32'h00000000;
            end
        end
    end

    // reserved bits never reach the functional outputs
    // amplitude select and error steer routed to analog
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            input_a_gain_adjust <= 8'h00;
            input_b_gain_adjust <= 8'h00;
            reference_voltage_adjust <= 4'h0;
            input_a_termination_adjust <= 8'h00;
            input_b_termination_adjust <= 8'h00;
            dither_control <= '{dither_on: 1'b1, dither_large_select: 1'b0,
                rounding_error_steer: 1'b0};
            fuse_loaded <= 1'b0;
        end else begin
            input_a_gain_adjust <= gain_a_reg;
            input_b_gain_adjust <= gain_b_reg;
            reference_voltage_adjust <= ref_reg[`REF_TRIM_MSB:0];
            input_a_termination_adjust <= term_a_reg;
            input_b_termination_adjust <= term_b_reg;
            dither_control.dither_on <= dither_reg[`DITHER_ON_BIT];
            dither_control.dither_large_select <= dither_reg[`DITHER_LARGE_BIT];
            dither_control.rounding_error_steer <= dither_reg[`ROUND_STEER_BIT];
            fuse_loaded <= loaded;
        end
    end

    // assertions
    sequence s_write_done(logic [9:0] r);
        psel && penable && pwrite && pready && pstrb[0] && idx == r;
    endsequence

    sequence s_read_setup(logic [9:0] r);
        setup && !pwrite && idx == r;
    endsequence

    property p_gain_a_write;
        @(posedge clk) disable iff (!rst_n)
        s_write_done(`GAIN_A_IDX) ##0 !load_pulse |=> gain_a_reg == $past(pwdata[7:0]);
    endproperty
    a_gain_a_write: assert property (p_gain_a_write) else $error("gain a write lost");

    property p_strobe_off;
        @(posedge clk) disable iff (!rst_n)
        psel && penable && pwrite && pready && !pstrb[0] && !load_pulse |=>
            $stable(gain_a_reg) && $stable(dither_reg);
    endproperty
    a_strobe_off: assert property (p_strobe_off) else $error("write without strobe stored");

    property p_gain_b_write;
        @(posedge clk) disable iff (!rst_n)
        s_write_done(`GAIN_B_IDX) ##0 !load_pulse |=> gain_b_reg == $past(pwdata[7:0]);
    endproperty
    a_gain_b_write: assert property (p_gain_b_write) else $error("gain b write lost");

    property p_gain_b_out;
        @(posedge clk) disable iff (!rst_n)
        s_write_done(`GAIN_B_IDX) ##0 !load_pulse |=> ##1 input_b_gain_adjust ==
            $past(pwdata[7:0], 2);
    endproperty
    a_gain_b_out: assert property (p_gain_b_out) else $error("gain b output wrong");

    property p_ref_out;
        @(posedge clk) disable iff (!rst_n)
        ##1 reference_voltage_adjust == $past(ref_reg[3:0]);
    endproperty
    a_ref_out: assert property (p_ref_out) else $error("reference trim output wrong");

    property p_ref_write;
        @(posedge clk) disable iff (!rst_n)
        s_write_done(`REF_IDX) ##0 !load_pulse |=> ref_reg == $past(pwdata[7:0]);
    endproperty
    a_ref_write: assert property (p_ref_write) else $error("reference write lost");

    property p_term_a_write;
        @(posedge clk) disable iff (!rst_n)
        s_write_done(`TERM_A_IDX) ##0 !load_pulse |=> term_a_reg == $past(pwdata[7:0]);
    endproperty
    a_term_a_write: assert property (p_term_a_write) else $error("term a write lost");

    property p_term_a_out;
        @(posedge clk) disable iff (!rst_n)
        s_write_done(`TERM_A_IDX) ##0 !load_pulse |=> ##1 input_a_termination_adjust ==
            $past(pwdata[7:0], 2);
    endproperty
    a_term_a_out: assert property (p_term_a_out) else $error("term a output wrong");

    property p_term_b_write;
        @(posedge clk) disable iff (!rst_n)
        s_write_done(`TERM_B_IDX) ##0 !load_pulse |=> term_b_reg == $past(pwdata[7:0]);
    endproperty
    a_term_b_write: assert property (p_term_b_write) else $error("term b write lost");

    property p_term_b_read;
        @(posedge clk) disable iff (!rst_n)
        setup && !pwrite && idx == `TERM_B_IDX |=> prdata[7:0] == $past(term_b_reg);
    endproperty
    a_term_b_read: assert property (p_term_b_read) else $error("term b read wrong");

    property p_fuse_load;
        @(posedge clk) disable iff (!rst_n)
        load_pulse |=> gain_a_reg == $past(fuse_trim.gain_a) &&
            dither_reg == $past(fuse_trim.dither);
    endproperty
    a_fuse_load: assert property (p_fuse_load) else $error("fuse value not loaded");

    property p_fuse_rest;
        @(posedge clk) disable iff (!rst_n)
        load_pulse |=> gain_b_reg == $past(fuse_trim.gain_b) &&
            ref_reg == $past(fuse_trim.reference) && term_a_reg == $past(fuse_trim.term_a) &&
            term_b_reg == $past(fuse_trim.term_b);
    endproperty
    a_fuse_rest: assert property (p_fuse_rest) else $error("fuse trims not loaded");

    property p_gain_a_read;
        @(posedge clk) disable iff (!rst_n)
        s_read_setup(`GAIN_A_IDX) |=> prdata[7:0] == $past(gain_a_reg);
    endproperty
    a_gain_a_read: assert property (p_gain_a_read) else $error("gain a read wrong");

    property p_dither_on;
        @(posedge clk) disable iff (!rst_n)
        ##1 dither_control.dither_on == $past(dither_reg[0]) &&
            dither_control.dither_large_select == $past(dither_reg[1]);
    endproperty
    a_dither_on: assert property (p_dither_on) else $error("dither controls wrong");

    property p_dither_large_out;
        @(posedge clk) disable iff (!rst_n)
        s_write_done(`DITHER_IDX) ##0 !load_pulse |=> ##1 dither_control.dither_large_select ==
            $past(pwdata[`DITHER_LARGE_BIT], 2);
    endproperty
    a_dither_large_out: assert property (p_dither_large_out) else $error("amplitude wrong");

    property p_round_steer_out;
        @(posedge clk) disable iff (!rst_n)
        s_write_done(`DITHER_IDX) ##0 !load_pulse |=> ##1 dither_control.rounding_error_steer ==
            $past(pwdata[`ROUND_STEER_BIT], 2);
    endproperty
    a_round_steer_out: assert property (p_round_steer_out) else $error("steer wrong");

    property p_dither_reset;
        @(posedge clk)
        !rst_n |=> dither_reg == `DITHER_RESET;
    endproperty
    a_dither_reset: assert property (p_dither_reset) else $error("dither reset wrong");

    property p_dither_store;
        @(posedge clk) disable iff (!rst_n)
        s_write_done(`DITHER_IDX) ##0 !load_pulse |=> dither_reg == $past(pwdata[7:0]);
    endproperty
    a_dither_store: assert property (p_dither_store) else $error("dither bits lost");

    property p_err_unmapped;
        @(posedge clk) disable iff (!rst_n)
        setup && !hit |=> pready && pslverr;
    endproperty
    a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped not refused"); // bus

    property p_ready_one;
        @(posedge clk) disable iff (!rst_n)
        setup |=> pready ##1 !pready;
    endproperty
    a_ready_one: assert property (p_ready_one) else $error("ready timing wrong"); // bus timing
endmodule

/* tb_trim_dither_register_bank.sv */
// self-checking bench for the trim/dither register bank over apb
// assumes trim_map.svh and trim_pkg; fuse settle shortened to one cycle
`include "trim_map.svh"
module tb_trim_dither_register_bank
    import trim_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk;
    logic rst_n;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    trim_set_type fuse_trim;
    logic [7:0] input_a_gain_adjust;
    logic [7:0] input_b_gain_adjust;
    logic [3:0] reference_voltage_adjust;
    logic [7:0] input_a_termination_adjust;
    logic [7:0] input_b_termination_adjust;
    dither_ctl_type dither_control;
    logic fuse_loaded;
    int errors = 0;
    int num_checks = 0;
    logic [7:0] outs [5];
    logic [9:0] idxs [5] = '{`GAIN_A_IDX, `GAIN_B_IDX, `REF_IDX, `TERM_A_IDX, `TERM_B_IDX};
    logic [7:0] fz [6] = '{8'h3C, 8'hC3, 8'h05, 8'h96, 8'h69, 8'h03};
    logic [7:0] mask [5] = '{8'hFF, 8'hFF, 8'h0F, 8'hFF, 8'hFF};
    logic [7:0] p;
    logic [7:0] d;
    int n;

    assign outs[0] = input_a_gain_adjust;
    assign outs[1] = input_b_gain_adjust;
    assign outs[2] = {4'h0, reference_voltage_adjust};
    assign outs[3] = input_a_termination_adjust;
    assign outs[4] = input_b_termination_adjust;

    trim_dither_register_bank #(.SETTLE_CYCLES(1)) i_trim_dither_register_bank (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fuse_trim(fuse_trim),
        .input_a_gain_adjust(input_a_gain_adjust),
        .input_b_gain_adjust(input_b_gain_adjust),
        .reference_voltage_adjust(reference_voltage_adjust),
        .input_a_termination_adjust(input_a_termination_adjust),
        .input_b_termination_adjust(input_b_termination_adjust),
        .dither_control(dither_control), .fuse_loaded(fuse_loaded));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // one apb transfer; waits for pready under a bound, never a fixed count
    task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] dat,
            input logic [3:0] s, output logic [31:0] rd, output logic err);
        int k;
        k = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, dat};
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 16) begin
            errors++;
            tally_and_finish();
        end
    endtask

    task automatic wr(input logic [9:0] idx, input logic [7:0] dat, input logic [3:0] s,
            input logic e);
        logic [31:0] rd;
        logic err;
        apb(1'b1, idx, dat, s, rd, err);
        chk("write error flag", {31'h0, e}, {31'h0, err});
    endtask

    task automatic rdc(input logic [9:0] idx, input logic [7:0] exp, input logic e);
        logic [31:0] rd;
        logic err;
        apb(1'b0, idx, 8'h00, 4'h0, rd, err);
        chk("read data", {24'h0, exp}, rd);
        chk("read error flag", {31'h0, e}, {31'h0, err});
    endtask

    // outputs trail the stored register by one cycle
    task automatic settle();
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask

    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'h0;
        fuse_trim = {fz[0], fz[1], fz[2], fz[3], fz[4], fz[5]};
        repeat (8) @(posedge clk);
        @(negedge clk);
        chk("dither out in reset", 32'h4, {29'h0, dither_control});
        @(posedge clk);
        rst_n <= 1'b1;
        n = 0;
        while (fuse_loaded !== 1'b1 && n < 64) begin
            @(posedge clk);
            n++;
        end
        if (n >= 64) begin
            errors++;
            tally_and_finish();
        end
        rdc(`FUSE_STATUS_IDX, 8'h01, 1'b0);
        for (int i = 0; i < 5; i++) begin
            rdc(idxs[i], fz[i], 1'b0);
        end
        rdc(`DITHER_IDX, fz[5], 1'b0);
        settle();
        for (int i = 0; i < 5; i++) begin
            chk("fuse trim out", {24'h0, fz[i] & mask[i]}, {24'h0, outs[i]});
        end
        // writes with an idle cycle between each, then readback of every trim incl. reserved bits
        foreach (fz[j]) begin
            if (j < 2) begin
                p = (j == 0) ? 8'hA5 : 8'h5A;
                for (int i = 0; i < 5; i++) begin
                    wr(idxs[i], p ^ 8'(i), 4'hF, 1'b0);
                end
                for (int i = 0; i < 5; i++) begin
                    rdc(idxs[i], p ^ 8'(i), 1'b0);
                end
                settle();
                for (int i = 0; i < 5; i++) begin
                    chk("trim out", {24'h0, (p ^ 8'(i)) & mask[i]}, {24'h0, outs[i]});
                end
            end
        end
        // strobe off means no store
        wr(`GAIN_A_IDX, 8'hFF, 4'hE, 1'b0);
        rdc(`GAIN_A_IDX, 8'h5A, 1'b0);
        // unmapped hole between trims is refused and leaves the reference trim below it alone
        wr(10'h07D, 8'h77, 4'hF, 1'b1);
        rdc(10'h07D, 8'h00, 1'b1);
        rdc(`REF_IDX, 8'h58, 1'b0);
        // every dither code with reserved bits varying
        for (int v = 0; v < 8; v++) begin
            d = 8'(v * 37);
            wr(`DITHER_IDX, d, 4'hF, 1'b0);
            rdc(`DITHER_IDX, d, 1'b0);
            settle();
            chk("dither out", {29'h0, d[0], d[1], d[2]}, 32'(dither_control));
        end
        tally_and_finish();
    end
endmodule
